// ### logic/ebc_regs.svh
// Constants of the expansion bus controller: widths, phase indices, reset values.
`ifndef EBC_REGS_SVH
`define EBC_REGS_SVH
`define EBC_ADDR_W      24
`define EBC_DATA_W      16
`define EBC_NUM_CS      4
`define EBC_NUM_MST     4
`define EBC_REGION_MIN  5'h09
`define EBC_STRAP_RST   24'hffffff
`define EBC_PH_ADDR     0
`define EBC_PH_SETUP    1
`define EBC_PH_STROBE   2
`define EBC_PH_HOLD     3
`define EBC_PH_RECOV    4
`define EBC_NUM_PHASES  5
`endif

// ### logic/ebc_pkg.sv
// Types shared by the expansion bus controller.
`include "ebc_regs.svh"
package ebc_pkg;
    typedef enum logic [2:0] {
        EBC_ST_A_MUX   = 3'h0,
        EBC_ST_A_SEP   = 3'h1,
        EBC_ST_B_MUX   = 3'h2,
        EBC_ST_B_SEP   = 3'h3,
        EBC_ST_FLASH   = 3'h4,
        EBC_ST_SFLASH  = 3'h5
    } ebc_style_e;
    typedef struct packed {
        logic                                   enable;
        ebc_style_e                             style;
        logic                                   wide16;
        logic                                   wait_en;
        logic [3:0]                             size_log;
        logic [14:0]                            base;
        logic [`EBC_NUM_PHASES-1:0][3:0]        phase_len;
    } ebc_cs_cfg_s;
    typedef struct packed {
        logic                   write;
        logic                   half;
        logic [`EBC_ADDR_W-1:0] addr;
        logic [`EBC_DATA_W-1:0] wdata;
    } ebc_req_s;
    typedef enum logic [6:0] {
        EBC_L_IDLE   = 7'h01,
        EBC_L_ADDR   = 7'h02,
        EBC_L_SETUP  = 7'h04,
        EBC_L_STROBE = 7'h08,
        EBC_L_HOLD   = 7'h10,
        EBC_L_RECOV  = 7'h20,
        EBC_L_EXT    = 7'h40
    } ebc_link_e;
endpackage : ebc_pkg

// ### logic/ebc_top.sv
// Expansion bus controller: core request port, bus cycle engine, arbiter and strap capture.
`timescale 1ns/1ps
`default_nettype none
module ebc_top
    import ebc_pkg::*;
(
    input  wire logic                   clock,            // Core clock, 200 MHz.
    input  wire logic                   rst_n,            // Synchronous reset, active low.
    input  wire logic                   bus_clock_in,     // Expansion bus clock.
    input  wire logic                   req_valid,        // Core request present.
    output logic                        req_ready,        // Controller can take a request.
    input  wire ebc_req_s               req,              // Request word.
    output logic                        rsp_valid,        // One-cycle completion pulse.
    output logic                        rsp_err,          // No region matched.
    output logic [`EBC_DATA_W-1:0]      rsp_data,         // Read data.
    input  wire ebc_cs_cfg_s [3:0]      cs_cfg,           // Per-region timing and control.
    input  wire logic                   strap_we,         // Rewrite captured straps.
    input  wire logic [`EBC_ADDR_W-1:0] strap_wdata,      // New strap value.
    output logic [`EBC_ADDR_W-1:0]      strap_value,      // Configuration word 0.
    output logic [`EBC_ADDR_W-1:0]      bus_address_out,  // Address lines, driven value.
    input  wire logic [`EBC_ADDR_W-1:0] bus_address_in,   // Address lines, pin level.
    output logic                        bus_address_oe_n, // Address drive enable, low drives.
    output logic [`EBC_DATA_W-1:0]      bus_data_out,     // Data lines, driven value.
    input  wire logic [`EBC_DATA_W-1:0] bus_data_in,      // Data lines, pin level.
    output logic                        bus_data_oe_n,    // Data drive enable, low drives.
    output logic                        address_latch_enable, // Address latch pulse.
    output logic                        read_strobe_n,    // Read strobe.
    output logic                        write_strobe_n,   // Write strobe.
    output logic                        strobe_oe_n,      // Strobe and latch drive enable.
    output logic [`EBC_NUM_CS-1:0]      region_select_n,  // Chip selects.
    input  wire logic                   wait_request_n,   // Access stretch request.
    input  wire logic [`EBC_NUM_MST-1:0] ext_request_n,   // External master requests.
    output logic [`EBC_NUM_MST-1:0]     ext_grant_n       // External master grants.
);

    typedef struct packed {
        logic                   busy;
        logic                   ready;
        logic                   req_tgl;
        ebc_req_s               req;
        logic                   done_s1;
        logic                   done_s2;
        logic                   done_seen;
        logic                   rsp_valid;
        logic                   rsp_err;
        logic [`EBC_DATA_W-1:0] rsp_data;
        logic                   strap_pend;
        logic [`EBC_ADDR_W-1:0] strap;
        logic [`EBC_ADDR_W-1:0] addr_s1;
        logic [`EBC_ADDR_W-1:0] addr_s2;
    } ebc_sys_s;

    typedef struct packed {
        ebc_link_e               st;
        logic [3:0]              cnt;
        logic [1:0]              idx;
        logic                    beat;
        logic                    req_s1;
        logic                    req_s2;
        logic                    req_seen;
        logic                    wait_s1;
        logic                    wait_s2;
        logic [`EBC_NUM_MST-1:0] ereq_s1;
        logic [`EBC_NUM_MST-1:0] ereq_s2;
        logic [`EBC_ADDR_W-1:0]  eaddr_s1;
        logic [`EBC_ADDR_W-1:0]  eaddr_s2;
        logic [`EBC_DATA_W-1:0]  data_s1;
        logic [`EBC_DATA_W-1:0]  data_s2;
        logic [1:0]              owner;
        logic                    done_tgl;
        logic [`EBC_DATA_W-1:0]  rdata;
        logic                    err;
        logic [`EBC_ADDR_W-1:0]  addr_o;
        logic                    addr_oe_n;
        logic [`EBC_DATA_W-1:0]  data_o;
        logic                    data_oe_n;
        logic                    ale;
        logic                    rd_n;
        logic                    wr_n;
        logic                    strobe_oe_n;
        logic [`EBC_NUM_CS-1:0]  cs_n;
        logic [`EBC_NUM_MST-1:0] gnt_n;
    } ebc_link_s;

    // Region decode
    // Lowest matching chip select wins; the region spans 512 bytes shifted by size_log.
    function automatic logic [2:0] ebc_decode(input ebc_cs_cfg_s [3:0] cfg,
                                              input logic [`EBC_ADDR_W-1:0] a);
        logic [2:0]             r;
        logic [`EBC_ADDR_W-1:0] m;
        r = 3'h0;
        for (int i = `EBC_NUM_CS - 1; i >= 0; i--) begin
            m = `EBC_STRAP_RST << ({1'b0, cfg[i].size_log} + `EBC_REGION_MIN);
            if (cfg[i].enable && ((a & m) == ({cfg[i].base, 9'h000} & m))) begin
                r = {1'b1, 2'(i)};
            end
        end
        return r;
    endfunction : ebc_decode

    function automatic logic ebc_is_mux(input ebc_style_e s);
        return (s == EBC_ST_A_MUX) || (s == EBC_ST_B_MUX);
    endfunction : ebc_is_mux

    ebc_sys_s  sq;
    ebc_sys_s  sn;
    ebc_link_s lq;
    ebc_link_s ln;
    logic [1:0] lrst_q;

    // Core clock domain: request hand-off, completion pickup and strap capture.
    always_comb begin
        sn = sq;
        sn.rsp_valid = 1'b0;
        sn.addr_s1 = bus_address_in;
        sn.addr_s2 = sq.addr_s1;
        sn.done_s1 = lq.done_tgl;
        sn.done_s2 = sq.done_s1;
        if (sq.strap_pend) begin
            sn.strap      = sq.addr_s2;
            sn.strap_pend = 1'b0;
        end else if (strap_we) begin
            sn.strap = strap_wdata;
        end
        if (sq.busy && (sq.done_s2 != sq.done_seen)) begin
            // The link holds rdata and err stable until the next request toggle.
            sn.done_seen = sq.done_s2;
            sn.busy      = 1'b0;
            sn.rsp_valid = 1'b1;
            sn.rsp_data  = lq.rdata;
            sn.rsp_err   = lq.err;
        end else if (!sq.busy && req_valid) begin
            sn.busy    = 1'b1;
            sn.req     = req;
            sn.req_tgl = ~sq.req_tgl;
        end
        sn.ready = ~sn.busy;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sq <= '{strap: `EBC_STRAP_RST, strap_pend: 1'b1, addr_s1: bus_address_in,
                    addr_s2: sq.addr_s1, default: '0};
        end else begin
            sq <= sn;
        end
    end

    // Link reset
    // The bus clock is unrelated to the core clock, so reset is brought over by two flops.
    always_ff @(posedge bus_clock_in) begin
        lrst_q <= {lrst_q[0], rst_n};
    end

    // Bus clock domain: arbiter and five-phase cycle engine.
    always_comb begin
        logic [2:0]             hit;
        logic [`EBC_ADDR_W-1:0] ea;
        ebc_cs_cfg_s            c;
        hit = 3'h0;
        ea  = '0;
        c   = cs_cfg[lq.idx];
        ln  = lq;
        ln.req_s1   = sq.req_tgl;
        ln.req_s2   = lq.req_s1;
        ln.wait_s1  = wait_request_n;
        ln.wait_s2  = lq.wait_s1;
        ln.ereq_s1  = ext_request_n;
        ln.ereq_s2  = lq.ereq_s1;
        ln.eaddr_s1 = bus_address_in;
        ln.eaddr_s2 = lq.eaddr_s1;
        ln.data_s1  = bus_data_in;
        ln.data_s2  = lq.data_s1;
        ln.ale      = 1'b0;
        if (lq.cnt != 4'h0) begin
            ln.cnt = lq.cnt - 4'h1;
        end
        unique case (lq.st)
            EBC_L_IDLE: begin
                hit = ebc_decode(cs_cfg, sq.req.addr);
                if (lq.req_s2 != lq.req_seen) begin
                    ln.req_seen = lq.req_s2;
                    ln.beat     = 1'b0;
                    if (!hit[2]) begin
                        ln.err      = 1'b1;
                        ln.done_tgl = ~lq.done_tgl;
                    end else begin
                        c             = cs_cfg[hit[1:0]];
                        ln.err        = 1'b0;
                        ln.idx        = hit[1:0];
                        ln.st         = EBC_L_ADDR;
                        ln.cnt        = c.phase_len[`EBC_PH_ADDR];
                        ln.addr_o     = sq.req.addr;
                        ln.addr_oe_n  = 1'b0;
                        ln.strobe_oe_n = 1'b0;
                        if (ebc_is_mux(c.style)) begin
                            ln.data_o    = sq.req.addr[`EBC_DATA_W-1:0];
                            ln.data_oe_n = 1'b0;
                            ln.ale       = 1'b1;
                        end
                    end
                end else if (lq.ereq_s2 != 4'hf) begin
                    for (int i = `EBC_NUM_MST - 1; i >= 0; i--) begin
                        if (!lq.ereq_s2[i]) begin
                            ln.owner = 2'(i);
                        end
                    end
                    ln.gnt_n = ~(4'h1 << ln.owner);
                    ln.st    = EBC_L_EXT;
                end
            end
            EBC_L_ADDR: begin
                if (lq.cnt == 4'h0) begin
                    ln.st     = EBC_L_SETUP;
                    ln.cnt    = c.phase_len[`EBC_PH_SETUP];
                    ln.cs_n   = ~(4'h1 << lq.idx);
                    ln.data_oe_n = ~sq.req.write;
                    ln.data_o = (!c.wide16 && lq.beat) ? {8'h00, sq.req.wdata[15:8]}
                                                      : sq.req.wdata;
                end else if (ebc_is_mux(c.style)) begin
                    ln.ale = 1'b1;
                end
            end
            EBC_L_SETUP: begin
                if (lq.cnt == 4'h0) begin
                    ln.st  = EBC_L_STROBE;
                    ln.cnt = c.phase_len[`EBC_PH_STROBE];
                    ln.rd_n = sq.req.write;
                    ln.wr_n = ~sq.req.write;
                end
            end
            EBC_L_STROBE: begin
                if (lq.cnt == 4'h0 && !(c.wait_en && c.style != EBC_ST_SFLASH && !lq.wait_s2))
                begin
                    ln.st   = EBC_L_HOLD;
                    ln.cnt  = c.phase_len[`EBC_PH_HOLD];
                    ln.rd_n = 1'b1;
                    ln.wr_n = 1'b1;
                    if (c.wide16) begin
                        ln.rdata = lq.data_s2;
                    end else if (lq.beat) begin
                        ln.rdata[15:8] = lq.data_s2[7:0];
                    end else begin
                        ln.rdata[7:0] = lq.data_s2[7:0];
                    end
                end
            end
            EBC_L_HOLD: begin
                if (lq.cnt == 4'h0) begin
                    ln.st        = EBC_L_RECOV;
                    ln.cnt       = c.phase_len[`EBC_PH_RECOV];
                    ln.cs_n      = 4'hf;
                    ln.data_oe_n = 1'b1;
                end
            end
            EBC_L_RECOV: begin
                if (lq.cnt == 4'h0) begin
                    if (!c.wide16 && sq.req.half && !lq.beat) begin
                        ln.beat   = 1'b1;
                        ln.st     = EBC_L_ADDR;
                        ln.cnt    = c.phase_len[`EBC_PH_ADDR];
                        ea        = sq.req.addr + 24'h000001;
                        ln.addr_o = ea;
                        if (ebc_is_mux(c.style)) begin
                            ln.data_o    = ea[`EBC_DATA_W-1:0];
                            ln.data_oe_n = 1'b0;
                            ln.ale       = 1'b1;
                        end
                    end else begin
                        ln.st          = EBC_L_IDLE;
                        ln.addr_oe_n   = 1'b1;
                        ln.strobe_oe_n = 1'b1;
                        ln.done_tgl    = ~lq.done_tgl;
                    end
                end
            end
            EBC_L_EXT: begin
                hit     = ebc_decode(cs_cfg, lq.eaddr_s2);
                ln.cs_n = hit[2] ? ~(4'h1 << hit[1:0]) : 4'hf;
                if (lq.ereq_s2[lq.owner]) begin
                    ln.gnt_n = 4'hf;
                    ln.cs_n  = 4'hf;
                    ln.st    = EBC_L_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge bus_clock_in) begin
        if (!lrst_q[1]) begin
            lq <= '{st: EBC_L_IDLE, addr_oe_n: 1'b1, data_oe_n: 1'b1, strobe_oe_n: 1'b1,
                    rd_n: 1'b1, wr_n: 1'b1, cs_n: 4'hf, gnt_n: 4'hf, wait_s1: 1'b1,
                    wait_s2: 1'b1, ereq_s1: 4'hf, ereq_s2: 4'hf, default: '0};
        end else begin
            lq <= ln;
        end
    end

    assign req_ready            = sq.ready;
    assign rsp_valid            = sq.rsp_valid;
    assign rsp_err              = sq.rsp_err;
    assign rsp_data             = sq.rsp_data;
    assign strap_value          = sq.strap;
    assign bus_address_out      = lq.addr_o;
    assign bus_address_oe_n     = lq.addr_oe_n;
    assign bus_data_out         = lq.data_o;
    assign bus_data_oe_n        = lq.data_oe_n;
    assign address_latch_enable = lq.ale;
    assign read_strobe_n        = lq.rd_n;
    assign write_strobe_n       = lq.wr_n;
    assign strobe_oe_n          = lq.strobe_oe_n;
    assign region_select_n      = lq.cs_n;
    assign ext_grant_n          = lq.gnt_n;

endmodule : ebc_top
`default_nettype wire

// ### verification/ebc_top_sva.sv
// Port checker for the expansion bus controller, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
`include "ebc_regs.svh"
module ebc_top_sva
    import ebc_pkg::*;
(
    input wire logic                    clock,                // Core clock.
    input wire logic                    rst_n,                // Reset, active low.
    input wire logic                    bus_clock_in,         // Bus clock.
    input wire logic                    req_valid,            // Request present.
    input wire logic                    req_ready,            // Request can be taken.
    input wire logic                    rsp_valid,            // Completion pulse.
    input wire logic [`EBC_ADDR_W-1:0]  strap_value,          // Strap word.
    input wire logic [`EBC_ADDR_W-1:0]  bus_address_in,       // Address pin level.
    input wire logic                    bus_address_oe_n,     // Address drive enable.
    input wire logic                    bus_data_oe_n,        // Data enable.
    input wire logic                    strobe_oe_n,          // Strobe enable.
    input wire logic                    address_latch_enable, // Latch pulse.
    input wire logic                    read_strobe_n,        // Read strobe.
    input wire logic                    write_strobe_n,       // Write strobe.
    input wire logic [`EBC_NUM_CS-1:0]  region_select_n,      // Chip selects.
    input wire logic [`EBC_NUM_MST-1:0] ext_request_n,        // Master requests.
    input wire logic [`EBC_NUM_MST-1:0] ext_grant_n           // Master grants.
);
    a_strobe_exclusive: assert property (@(posedge bus_clock_in) disable iff (!rst_n)
        read_strobe_n || write_strobe_n) else $error("both strobes low");
    a_strobe_drive: assert property (@(posedge bus_clock_in) disable iff (!rst_n)
        (!read_strobe_n || !write_strobe_n) |-> !strobe_oe_n && bus_data_oe_n == write_strobe_n)
        else $error("strobe drive enable wrong");
    a_strobe_in_select: assert property (@(posedge bus_clock_in) disable iff (!rst_n)
        (!read_strobe_n || !write_strobe_n) |-> region_select_n != 4'hf)
        else $error("strobe without a chip select");
    a_select_onehot: assert property (@(posedge bus_clock_in) disable iff (!rst_n)
        $onehot0(~region_select_n)) else $error("two chip selects low");
    a_latch_apart: assert property (@(posedge bus_clock_in) disable iff (!rst_n)
        address_latch_enable |-> region_select_n == 4'hf && read_strobe_n && write_strobe_n)
        else $error("latch pulse overlaps data phase");
    a_grant_drop: assert property (@(posedge bus_clock_in) disable iff (!rst_n)
        (ext_request_n == 4'hf)[*4] |-> ext_grant_n == 4'hf) else $error("grant without request");
    a_rsp_pulse: assert property (@(posedge clock) disable iff (!rst_n)
        rsp_valid |=> !rsp_valid) else $error("completion longer than one cycle");
    a_busy_after_take: assert property (@(posedge clock) disable iff (!rst_n)
        req_valid && req_ready |=> (!req_ready)[*3]) else $error("ready while busy");
    a_strap_reset: assert property (@(posedge clock)
        !rst_n |=> strap_value == `EBC_STRAP_RST) else $error("strap reset value wrong");
    a_strap_capture: assert property (@(posedge clock)
        $rose(rst_n) |=> strap_value == $past(bus_address_in, 2)) else $error("strap not captured");
    a_pins_released: assert property (@(posedge bus_clock_in)
        (!rst_n)[*4] |-> bus_address_oe_n && region_select_n == 4'hf)
        else $error("bus driven during reset");
    c_read: cover property (@(posedge bus_clock_in) !read_strobe_n);
    c_write: cover property (@(posedge bus_clock_in) !write_strobe_n);
    c_grant: cover property (@(posedge bus_clock_in) ext_grant_n != 4'hf);
endmodule : ebc_top_sva

bind ebc_top ebc_top_sva chk (.clock, .rst_n, .bus_clock_in, .req_valid, .req_ready, .rsp_valid,
    .strap_value, .bus_address_in, .bus_address_oe_n, .address_latch_enable, .read_strobe_n,
    .write_strobe_n, .region_select_n, .ext_request_n, .ext_grant_n, .bus_data_oe_n, .strobe_oe_n);
`default_nettype wire

// ### verification/ebc_periph_model.sv
// Peripheral and pin model on the far side of the expansion bus.
`timescale 1ns/1ps
`default_nettype none
module ebc_periph_model #(
    parameter logic [23:0] STRAP = 24'hf7ff5a // Lines with pull-downs read low.
) (
    input  wire logic        bus_clock_in,     // Bus clock.
    input  wire logic [23:0] bus_address_out,  // Driven address.
    input  wire logic        bus_address_oe_n, // Address enable.
    input  wire logic [15:0] bus_data_out,     // Driven data.
    input  wire logic        read_strobe_n,    // Read strobe.
    input  wire logic        write_strobe_n,   // Write strobe.
    input  wire logic [3:0]  region_select_n,  // Chip selects.
    input  wire logic [3:0]  wait_cycles,      // Stretch length.
    input  wire logic        master_on,        // Master drives address.
    input  wire logic [23:0] master_addr,      // Master address.
    output logic [23:0]      bus_address_in,   // Address pin level.
    output logic [15:0]      bus_data_in,      // Data pin level.
    output logic             wait_request_n    // Stretch, active low.
);
    logic [15:0] mem [0:1023];
    logic [23:0] lat_q;
    logic [15:0] last_q;
    logic [3:0]  wcnt_q;
    logic        stb;
    assign stb = !read_strobe_n || !write_strobe_n;
    // released lines read master_addr while master_on is set, else their pull level.
    assign bus_address_in = !bus_address_oe_n ? bus_address_out : (master_on ? master_addr : STRAP);
    // Released data lines flip every cycle so a stale capture cannot pass.
    assign bus_data_in = !read_strobe_n ? mem[lat_q[9:0]] : ~last_q;
    // wait stays high unless a stretch is asked for.
    assign wait_request_n = !(stb && wcnt_q < wait_cycles);
    always_ff @(posedge bus_clock_in) begin
        last_q <= bus_data_in;
        wcnt_q <= stb ? wcnt_q + 4'h1 : 4'h0;
        if (region_select_n == 4'hf && !bus_address_oe_n) begin
            lat_q <= bus_address_out;
        end
        if (!write_strobe_n) begin
            mem[lat_q[9:0]] <= bus_data_out;
        end
    end
endmodule : ebc_periph_model
`default_nettype wire

// ### verification/ebc_top_tb_top.sv
// Self-checking testbench for the expansion bus controller.
`timescale 1ns/1ps
`default_nettype none
`include "ebc_regs.svh"
module ebc_top_tb_top
    import ebc_pkg::*;
;
    localparam logic [23:0] STRAP = 24'hf7ff5a;
    localparam int          STB   = 4;
    logic              clock = 1'b0;
    logic              bus_clock_in = 1'b0;
    logic              rst_n = 1'b0;
    logic              req_valid, req_ready, rsp_valid, rsp_err, strap_we, master_on;
    ebc_req_s          req;
    ebc_cs_cfg_s [3:0] cs_cfg;
    logic [15:0]       rsp_data, bus_data_out, bus_data_in;
    logic [23:0]       strap_wdata, strap_value, bus_address_out, bus_address_in, master_addr;
    logic              bus_address_oe_n, bus_data_oe_n, address_latch_enable, strobe_oe_n;
    logic              read_strobe_n, write_strobe_n, wait_request_n;
    logic [3:0]        region_select_n, ext_request_n, ext_grant_n, wait_cycles;
    int                err_count = 0;
    int                total_checks = 0;
    int                stb_cnt = 0;
    int                ale_cnt = 0;

    always #2.5 clock = ~clock;
    // oscillator-fed bus clock, so the lower pin-fed limit does not apply.
    initial begin
        #1.3;
        forever #7.5 bus_clock_in = ~bus_clock_in;
    end
    always @(posedge bus_clock_in) begin
        stb_cnt += int'(!read_strobe_n || !write_strobe_n);
        ale_cnt += int'(address_latch_enable);
    end

    ebc_top dut (.clock, .rst_n, .bus_clock_in, .req_valid, .req_ready, .req, .rsp_valid,
        .rsp_err, .rsp_data, .cs_cfg, .strap_we, .strap_wdata, .strap_value, .bus_address_out,
        .bus_address_in, .bus_address_oe_n, .bus_data_out, .bus_data_in, .bus_data_oe_n,
        .address_latch_enable, .read_strobe_n, .write_strobe_n, .strobe_oe_n, .region_select_n,
        .wait_request_n, .ext_request_n, .ext_grant_n);
    ebc_periph_model #(.STRAP(STRAP)) model (.bus_clock_in, .bus_address_out, .bus_address_oe_n,
        .bus_data_out, .read_strobe_n, .write_strobe_n, .region_select_n, .wait_cycles,
        .master_on, .master_addr, .bus_address_in, .bus_data_in, .wait_request_n);

    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        total_checks++;
        if (exp !== got) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic timeout();
        err_count++;
        $display("Error wait expired");
        print_verdict();
    endtask : timeout

    task automatic await4(ref logic [3:0] sig, input logic [3:0] val, input logic eq);
        int n;
        for (n = 0; n < 400 && ((sig === val) != eq); n++) @(negedge clock);
        if (n == 400) timeout();
    endtask : await4

    // One core request, held until taken, then wait for its completion.
    task automatic op(input logic wr, input logic hf, input logic [23:0] a, input logic [15:0] wd);
        int n;
        stb_cnt = 0;
        ale_cnt = 0;
        req = '{write: wr, half: hf, addr: a, wdata: wd};
        req_valid = 1'b1;
        for (n = 0; n < 100 && req_ready !== 1'b1; n++) @(negedge clock);
        if (n == 100) timeout();
        @(negedge clock);
        req_valid = 1'b0;
        for (n = 0; n < 3000 && rsp_valid !== 1'b1; n++) @(negedge clock);
        if (n == 3000) timeout();
    endtask : op

    function automatic ebc_cs_cfg_s mk(input ebc_style_e st, input logic w16, input logic we,
                                       input logic [3:0] sz, input logic [14:0] base);
        mk = '{enable: 1'b1, style: st, wide16: w16, wait_en: we, size_log: sz, base: base,
               phase_len: {4'h1, 4'h1, 4'(STB), 4'h1, 4'h0}};
    endfunction : mk

    task automatic t_straps();
        check("straps", STRAP, strap_value);
        strap_wdata = 24'h5a0ff0;
        strap_we = 1'b1;
        @(negedge clock);
        strap_we = 1'b0;
        check("strap write", 24'h5a0ff0, strap_value);
    endtask : t_straps

    task automatic t_styles();
        for (int s = 0; s < 6; s++) begin
            cs_cfg[0].style = ebc_style_e'(s);
            op(1'b1, 1'b0, 24'(24'h1f0 + 2 * s), 16'(16'hc3a0 + s));
            check("write strobe", 24'(STB + 1), 24'(stb_cnt));
            op(1'b0, 1'b0, 24'(24'h1f0 + 2 * s), 16'h0);
            check("read data", 24'(16'hc3a0 + s), 24'(rsp_data));
            check("latch", 24'(s == 0 || s == 2), 24'(ale_cnt != 0));
        end
    endtask : t_styles

    task automatic t_byte();
        op(1'b1, 1'b1, 24'h000204, 16'ha55a);
        check("byte strobes", 24'(2 * (STB + 1)), 24'(stb_cnt));
        check("low byte first", 24'h5a, 24'(model.mem[10'h204][7:0]));
        op(1'b0, 1'b1, 24'h000204, 16'h0);
        check("byte read", 24'ha55a, 24'(rsp_data));
    endtask : t_byte

    task automatic t_wait();
        cs_cfg[0] = mk(EBC_ST_A_SEP, 1'b1, 1'b1, 4'h0, 15'h0);
        wait_cycles = 4'h3;
        op(1'b0, 1'b0, 24'h0001f0, 16'h0);
        check("stretched", 24'h1, 24'(stb_cnt > STB + 1));
        check("stretched data", 24'hc3a0, 24'(rsp_data));
        cs_cfg[0].style = EBC_ST_SFLASH;
        op(1'b0, 1'b0, 24'h0001f0, 16'h0);
        check("no stretch", 24'(STB + 1), 24'(stb_cnt));
        wait_cycles = 4'h0;
    endtask : t_wait

    task automatic t_unmapped();
        op(1'b0, 1'b0, 24'h003ffe, 16'h0);
        check("region two", 24'h0, 24'(rsp_err));
        op(1'b0, 1'b0, 24'h800000, 16'h0);
        check("unmapped", 24'h1, 24'(rsp_err));
        check("no cycle", 24'h0, 24'(stb_cnt));
    endtask : t_unmapped

    task automatic t_master();
        master_addr = 24'h000040;
        master_on = 1'b1;
        ext_request_n = 4'b0101;
        await4(ext_grant_n, 4'hf, 1'b0);
        check("grant", 24'hd, 24'(ext_grant_n));
        await4(region_select_n, 4'he, 1'b1);
        check("master select", 24'he, 24'(region_select_n));
        ext_request_n = 4'hf;
        await4(ext_grant_n, 4'hf, 1'b1);
        master_on = 1'b0;
        check("released", 24'hf, 24'(ext_grant_n));
    endtask : t_master

    initial begin
        req_valid = 1'b0;
        req = '0;
        cs_cfg[0] = mk(EBC_ST_A_SEP, 1'b1, 1'b0, 4'h0, 15'h0);
        cs_cfg[1] = mk(EBC_ST_B_MUX, 1'b0, 1'b0, 4'h0, 15'h1);
        cs_cfg[2] = mk(EBC_ST_FLASH, 1'b1, 1'b0, 4'h4, 15'h10);
        cs_cfg[3] = '0;
        strap_we = 1'b0;
        strap_wdata = 24'h0;
        ext_request_n = 4'hf;
        wait_cycles = 4'h0;
        master_on = 1'b0;
        master_addr = 24'h0;
        // Reset spans at least four bus clock edges as well.
        repeat (14) @(negedge clock);
        rst_n = 1'b1;
        repeat (2) @(negedge clock);
        t_straps();
        t_styles();
        t_byte();
        t_wait();
        t_unmapped();
        t_master();
        print_verdict();
    end
endmodule : ebc_top_tb_top
`default_nettype wire
